// >>> logic/atc_pkg.sv
// Shared constants for the converter trim and clock configuration bank
package atc_pkg;
  // ********************************************************
  // Register offsets on the configuration port
  // ********************************************************
  localparam logic [7:0] ADDR_PORT_CFG = 8'h00; // Port config, soft reset
  localparam logic [7:0] ADDR_C0_GCOARSE = 8'h22; // Core 0 coarse gain
  localparam logic [7:0] ADDR_C0_GMED = 8'h23; // Core 0 medium gain
  localparam logic [7:0] ADDR_C0_GFINE = 8'h24; // Core 0 fine gain
  localparam logic [7:0] ADDR_PWR_MODE = 8'h25; // Power mode control
  localparam logic [7:0] ADDR_C1_OCOARSE = 8'h26; // Core 1 coarse offset
  localparam logic [7:0] ADDR_C1_OFINE = 8'h27; // Core 1 fine offset
  localparam logic [7:0] ADDR_C1_GCOARSE = 8'h28; // Core 1 coarse gain
  localparam logic [7:0] ADDR_C1_GMED = 8'h29; // Core 1 medium gain
  localparam logic [7:0] ADDR_C1_GFINE = 8'h2a; // Core 1 fine gain
  localparam logic [7:0] ADDR_EDGE_SLIP = 8'h71; // Sampling edge slip
  localparam logic [7:0] ADDR_CLK_DIV = 8'h72; // Clock divider select
  localparam logic [7:0] ADDR_OUT_MODE_B = 8'h73; // Output mode, loop range
  // ********************************************************
  // Field positions and widths
  // ********************************************************
  localparam int SOFT_RST_BIT = 5; // Soft reset in port config
  localparam int SLIP_BIT = 0; // Edge slip request bit
  localparam int DLL_SLOW_BIT = 6; // Loop range, 1 = slow
  localparam int COARSE_W = 4; // Coarse gain width
  localparam int TRIM_W = 8; // Medium, fine and offset width
  localparam int NUM_TRIM = 8; // Trim registers held in the bank
  localparam int PM_W = 2; // Power mode field width
  localparam int DIV_W = 3; // Divider select field width
  // ********************************************************
  // Reset values and encodings
  // ********************************************************
  localparam logic [7:0] TRIM_RST = 8'h00; // Before calibration lands
  localparam logic [7:0] GAIN_MID = 8'h80; // No gain change
  localparam logic [1:0] PM_REG_PIN = 2'h0; // Power mode from pin
  localparam logic [1:0] PM_NORMAL = 2'h0; // Pin level and mode: normal
  localparam logic [1:0] PM_NAP = 2'h1; // Nap
  localparam logic [1:0] PM_SLEEP = 2'h2; // Sleep
  localparam logic [2:0] DIV_PIN = 3'h0; // Divider from pin
  localparam logic [2:0] DIV_BY1 = 3'h1; // Divide by one
  localparam logic [2:0] DIV_BY2 = 3'h2; // Divide by two
  localparam logic [1:0] DIVPIN_BY1 = 2'h0; // Divider pin low: by one
  // Coarse gain weights in tenths of a percent, bit 3 down to bit 0
  localparam logic signed [6:0] W_B3 = 7'sd28;
  localparam logic signed [6:0] W_B2 = 7'sd14;
  localparam logic signed [6:0] W_B1 = -7'sd28;
  localparam logic signed [6:0] W_B0 = -7'sd14;
endpackage

// >>> logic/atc_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module atc_sync #(
  parameter int W = 2 // Bits synchronised together
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic [W-1:0] d_i, // Asynchronous level
  output logic [W-1:0] q_o // Level after two flops
);
  logic [W-1:0] meta_r; // First stage, read only by second
  logic [W-1:0] q_r; // Second stage

  // Both stages clear on reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule
`default_nettype wire

// >>> logic/atc_divider_select_pin.sv
// Sampling edge generator: divider, edge slip and realignment
`timescale 1ns/1ps
`default_nettype none
module atc_divider_select_pin (
  input wire logic sys_clk_i, // Incoming sample clock
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic div2_i, // Divide by two selected
  input wire logic slip_i, // One-cycle slip request
  input wire logic realign_i, // Divider realignment, synchronised
  output logic sample_en_o // One-cycle sampling event
);
  logic cnt_r, cnt_nxt; // Phase within the divided period
  logic smp_r, smp_nxt; // Registered sampling event

  // Next phase: realign wins, a slip freezes the phase one cycle
  always_comb
  begin
    cnt_nxt = cnt_r;
    smp_nxt = 1'b0;
    if (realign_i)
      cnt_nxt = 1'b0;
    else if (slip_i)
      cnt_nxt = cnt_r;
    else
    begin
      cnt_nxt = div2_i ? ~cnt_r : 1'b0;
      smp_nxt = !cnt_r;
    end
  end

  // Register the phase and the event
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      cnt_r <= 1'b0;
      smp_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      smp_r <= smp_nxt;
    end
  end

  assign sample_en_o = smp_r;

  AST_DIV2_SPACING: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) div2_i && $past(div2_i) && sample_en_o
    |=> !sample_en_o) else $error("two samples in a row at divide by two");
  AST_SLIP_DELAY: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) slip_i && !realign_i |=> !sample_en_o)
    else $error("sample not delayed by slip");
  AST_REALIGN_STATE: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) realign_i |=> !cnt_r && !sample_en_o)
    else $error("realign did not reset phase");
endmodule
`default_nettype wire

// >>> logic/atc_cfg_regs.sv
// Trim and clock configuration bank behind the configuration port
`timescale 1ns/1ps
`default_nettype none
module atc_cfg_regs
  import atc_pkg::*;
(
  input wire logic sys_clk_i, // System clock, 10 MHz
  input wire logic rstn_i, // Synchronous reset, active low
  input wire logic cfg_wr_i, // Register write strobe
  input wire logic cfg_rd_i, // Register read strobe
  input wire logic [7:0] cfg_addr_i, // Register offset
  input wire logic [7:0] cfg_wdata_i, // Write data
  output logic [7:0] cfg_rdata_o, // Read data, one cycle after strobe
  input wire logic cal_load_i, // Calibration results valid pulse
  input wire logic [NUM_TRIM*TRIM_W-1:0] cal_trim_i, // Results, 0x22 first
  input wire logic [1:0] power_mode_pin_i, // Tri-level pin, asynchronous
  input wire logic [1:0] divider_select_pin_i, // Tri-level pin, async
  input wire logic realign_req_i, // Realignment from link sync, async
  output logic port_enabled_o, // Configuration port usable
  output logic [1:0] power_mode_o, // Effective power mode
  output logic divide_by2_o, // Effective divisor is two
  output logic sample_en_o, // Sampling event
  output logic dll_slow_o, // Loop range slow
  output logic [3:0] core0_gain_coarse_o, // Core 0 coarse gain
  output logic [7:0] core0_gain_medium_o, // Core 0 medium gain
  output logic [7:0] core0_gain_fine_o, // Core 0 fine gain
  output logic [7:0] core1_offset_coarse_o, // Core 1 coarse offset
  output logic [7:0] core1_offset_fine_o, // Core 1 fine offset
  output logic [3:0] core1_gain_coarse_o, // Core 1 coarse gain
  output logic [7:0] core1_gain_medium_o, // Core 1 medium gain
  output logic [7:0] core1_gain_fine_o, // Core 1 fine gain
  output logic signed [6:0] core0_coarse_pct_o, // Core 0 coarse, 0.1 %
  output logic signed [6:0] core1_coarse_pct_o // Core 1 coarse, 0.1 %
);
  // ********************************************************
  // Helpers
  // ********************************************************
  // Offset to trim slot; slot NUM_TRIM means no trim register
  function automatic logic [3:0] trim_slot(input logic [7:0] a);
    unique case (a)
      ADDR_C0_GCOARSE: trim_slot = 4'h0;
      ADDR_C0_GMED: trim_slot = 4'h1;
      ADDR_C0_GFINE: trim_slot = 4'h2;
      ADDR_C1_OCOARSE: trim_slot = 4'h3;
      ADDR_C1_OFINE: trim_slot = 4'h4;
      ADDR_C1_GCOARSE: trim_slot = 4'h5;
      ADDR_C1_GMED: trim_slot = 4'h6;
      ADDR_C1_GFINE: trim_slot = 4'h7;
      default: trim_slot = 4'h8;
    endcase
  endfunction

  // Coarse slots keep only four bits, the rest read zero
  function automatic logic [7:0] trim_mask(input logic [3:0] s);
    trim_mask = (s == 4'h0 || s == 4'h5) ? 8'h0f : 8'hff;
  endfunction

  // Nominal coarse gain of a four-bit pattern in tenths of a percent
  function automatic logic signed [6:0] coarse_pct(input logic [3:0] g);
    coarse_pct = (g[3] ? W_B3 : 7'sd0) + (g[2] ? W_B2 : 7'sd0)
      + (g[1] ? W_B1 : 7'sd0) + (g[0] ? W_B0 : 7'sd0);
  endfunction

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [1:0] pm_pin_s; // Power mode pin after two flops
  logic [1:0] div_pin_s; // Divider pin after two flops
  logic [0:0] realign_s; // Realign request after two flops
  logic realign_d_r; // Previous realign level, edge detect

  atc_sync #(.W(2)) u_pm_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i(power_mode_pin_i),
    .q_o(pm_pin_s)
  );

  atc_sync #(.W(2)) u_div_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i(divider_select_pin_i),
    .q_o(div_pin_s)
  );

  atc_sync #(.W(1)) u_rs_sync (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .d_i(realign_req_i),
    .q_o(realign_s)
  );

  // ********************************************************
  // Register state
  // ********************************************************
  logic [7:0] trim_r [NUM_TRIM]; // Gain and offset trims
  logic [7:0] trim_nxt [NUM_TRIM];
  logic [PM_W-1:0] pm_reg_r, pm_reg_nxt; // Power mode override
  logic [DIV_W-1:0] div_reg_r, div_reg_nxt; // Divider override
  logic dll_slow_r, dll_slow_nxt; // Loop range bit
  logic port_en_r, port_en_nxt; // Port unlocked
  logic [1:0] settle_r, settle_nxt; // Sync flops hold real pins once full
  logic slip_r, slip_nxt; // Self-clearing slip pulse
  logic [1:0] pm_out_r, pm_out_nxt; // Effective power mode
  logic div2_r, div2_nxt; // Effective divide by two
  logic [7:0] rdata_r, rdata_nxt; // Read data
  logic signed [6:0] pct0_r, pct0_nxt; // Core 0 coarse percent
  logic signed [6:0] pct1_r, pct1_nxt; // Core 1 coarse percent
  logic wr_ok; // Accepted write
  logic soft_rst; // Soft reset request this cycle
  logic [3:0] wslot; // Trim slot of the write offset
  logic [3:0] rslot; // Trim slot of the read offset

  assign wr_ok = cfg_wr_i && port_en_r;
  assign soft_rst = wr_ok && cfg_addr_i == ADDR_PORT_CFG
    && cfg_wdata_i[SOFT_RST_BIT];
  assign wslot = trim_slot(cfg_addr_i);
  assign rslot = trim_slot(cfg_addr_i);

  // Next register values: calibration, soft reset, then host writes
  always_comb
  begin
    for (int i = 0; i < NUM_TRIM; i++)
    begin
      trim_nxt[i] = trim_r[i];
      if (cal_load_i || soft_rst)
        trim_nxt[i] = cal_trim_i[i*TRIM_W +: TRIM_W]
          & trim_mask(i[3:0]);
      else if (wr_ok && wslot == i[3:0])
        trim_nxt[i] = cfg_wdata_i & trim_mask(i[3:0]);
    end
    pm_reg_nxt = pm_reg_r;
    div_reg_nxt = div_reg_r;
    dll_slow_nxt = dll_slow_r;
    slip_nxt = 1'b0;
    if (soft_rst)
      dll_slow_nxt = 1'b0;
    else if (wr_ok)
    begin
      unique case (cfg_addr_i)
        ADDR_PWR_MODE: pm_reg_nxt = cfg_wdata_i[PM_W-1:0];
        ADDR_CLK_DIV: div_reg_nxt = cfg_wdata_i[DIV_W-1:0];
        ADDR_OUT_MODE_B: dll_slow_nxt = cfg_wdata_i[DLL_SLOW_BIT];
        ADDR_EDGE_SLIP: slip_nxt = cfg_wdata_i[SLIP_BIT];
        default: slip_nxt = 1'b0;
      endcase
    end
    // Synchroniser reset value reads as normal, so ignore it until refilled
    settle_nxt = {settle_r[0], 1'b1};
    // Once unlocked the port stays usable until hard reset
    port_en_nxt = port_en_r || (settle_r[1] && pm_pin_s == PM_NORMAL);
    pm_out_nxt = (pm_reg_nxt == PM_REG_PIN) ? pm_pin_s
      : pm_reg_nxt - 2'h1;
    unique case (div_reg_nxt)
      DIV_BY1: div2_nxt = 1'b0;
      DIV_BY2: div2_nxt = 1'b1;
      // Prohibited codes fall back to the pin rather than guess
      default: div2_nxt = div_pin_s != DIVPIN_BY1;
    endcase
    pct0_nxt = coarse_pct(trim_nxt[0][3:0]);
    pct1_nxt = coarse_pct(trim_nxt[5][3:0]);
  end

  // Read mux; a locked port reads zero so nothing leaks before unlock
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (cfg_rd_i && port_en_r)
    begin
      if (rslot != 4'h8)
        rdata_nxt = trim_r[rslot[2:0]];
      else
      begin
        unique case (cfg_addr_i)
          ADDR_PWR_MODE: rdata_nxt = {6'h00, pm_reg_r};
          ADDR_CLK_DIV: rdata_nxt = {5'h00, div_reg_r};
          ADDR_OUT_MODE_B: rdata_nxt = {1'b0, dll_slow_r, 6'h00};
          default: rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  // Register everything; trims start at zero until calibration lands
  always_ff @(posedge sys_clk_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < NUM_TRIM; i++)
        trim_r[i] <= TRIM_RST;
      pm_reg_r <= PM_REG_PIN;
      div_reg_r <= DIV_PIN;
      dll_slow_r <= 1'b0;
      port_en_r <= 1'b0;
      settle_r <= 2'h0;
      slip_r <= 1'b0;
      pm_out_r <= PM_NORMAL;
      div2_r <= 1'b0;
      rdata_r <= 8'h00;
      pct0_r <= 7'sd0;
      pct1_r <= 7'sd0;
      realign_d_r <= 1'b0;
    end
    else
    begin
      trim_r <= trim_nxt;
      pm_reg_r <= pm_reg_nxt;
      div_reg_r <= div_reg_nxt;
      dll_slow_r <= dll_slow_nxt;
      port_en_r <= port_en_nxt;
      settle_r <= settle_nxt;
      slip_r <= slip_nxt;
      pm_out_r <= pm_out_nxt;
      div2_r <= div2_nxt;
      rdata_r <= rdata_nxt;
      pct0_r <= pct0_nxt;
      pct1_r <= pct1_nxt;
      realign_d_r <= realign_s[0];
    end
  end

  // ********************************************************
  // Sampling edge generator
  // ********************************************************
  atc_divider_select_pin u_divider_select_pin (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .div2_i(div2_r),
    .slip_i(slip_r),
    .realign_i(realign_s[0] && !realign_d_r),
    .sample_en_o(sample_en_o)
  );

  // Outputs, all from flip-flops
  assign cfg_rdata_o = rdata_r;
  assign port_enabled_o = port_en_r;
  assign power_mode_o = pm_out_r;
  assign divide_by2_o = div2_r;
  assign dll_slow_o = dll_slow_r;
  assign core0_gain_coarse_o = trim_r[0][COARSE_W-1:0];
  assign core0_gain_medium_o = trim_r[1];
  assign core0_gain_fine_o = trim_r[2];
  assign core1_offset_coarse_o = trim_r[3];
  assign core1_offset_fine_o = trim_r[4];
  assign core1_gain_coarse_o = trim_r[5][COARSE_W-1:0];
  assign core1_gain_medium_o = trim_r[6];
  assign core1_gain_fine_o = trim_r[7];
  assign core0_coarse_pct_o = pct0_r;
  assign core1_coarse_pct_o = pct1_r;

  // ********************************************************
  // Assertions
  // ********************************************************
  AST_COARSE_NIBBLE: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) cfg_rd_i && port_en_r
    && cfg_addr_i == ADDR_C0_GCOARSE |=> cfg_rdata_o[7:4] == 4'h0)
    else $error("coarse gain upper bits not zero");
  AST_COARSE_WEIGHT: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) wr_ok && cfg_addr_i == ADDR_C0_GCOARSE
    && cfg_wdata_i[3:0] == 4'h8 && !cal_load_i
    |=> core0_coarse_pct_o == 7'sd28)
    else $error("bit 3 weight not plus 2.8");
  AST_COARSE_RANGE: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) wr_ok && cfg_addr_i == ADDR_C1_GCOARSE
    && cfg_wdata_i[3:0] == 4'h3 && !cal_load_i
    |=> core1_coarse_pct_o == -7'sd42)
    else $error("0011 not minus 4.2");
  AST_MEDIUM_WRITE: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) wr_ok && cfg_addr_i == ADDR_C0_GMED
    && !cal_load_i |=> core0_gain_medium_o == $past(cfg_wdata_i))
    else $error("medium gain write lost");
  AST_CAL_LOAD: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) cal_load_i
    |=> core1_offset_fine_o == $past(cal_trim_i[39:32]))
    else $error("calibration result not loaded");
  AST_PIN_MODE: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) pm_reg_r == PM_REG_PIN ##1 pm_reg_r == PM_REG_PIN
    |-> power_mode_o == $past(pm_pin_s))
    else $error("power mode not following pin");
  AST_PORT_LOCK: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) !port_en_r ##1 !port_en_r
    |-> cfg_rdata_o == 8'h00 && pm_reg_r == PM_REG_PIN)
    else $error("locked port answered");
  AST_SOFT_KEEP: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) soft_rst
    |=> div_reg_r == $past(div_reg_r) && pm_reg_r == $past(pm_reg_r))
    else $error("soft reset changed kept registers");
  AST_DIV_BY2: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) div_reg_r == DIV_BY2 ##1 div_reg_r == DIV_BY2
    |-> divide_by2_o) else $error("code 010 not divide by two");
  AST_DLL_DEFAULT: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) soft_rst |=> !dll_slow_o)
    else $error("loop range not fast after soft reset");
  AST_SLIP_SELFCLR: assert property (@(posedge sys_clk_i)
    disable iff (!rstn_i) slip_r && !(wr_ok && cfg_addr_i == ADDR_EDGE_SLIP)
    |=> !slip_r) else $error("slip pulse longer than one cycle");

  COV_UNLOCK: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !port_en_r ##1 port_en_r);
  COV_SLIP: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    divide_by2_o && slip_r);
  COV_SOFT_RST: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
    soft_rst && div_reg_r != DIV_PIN);
endmodule
`default_nettype wire

// >>> sim/atc_host_model.sv
// Host controller model that drives the configuration port
`timescale 1ns/1ps
`default_nettype none
module atc_host_model (
  input wire logic sys_clk_i, // System clock
  input wire logic [7:0] cfg_rdata_i, // Read data from the bank
  output logic cfg_wr_o, // Write strobe
  output logic cfg_rd_o, // Read strobe
  output logic [7:0] cfg_addr_o, // Register offset
  output logic [7:0] cfg_wdata_o // Write data
);
  // ****************************************
  // Port driving
  // ****************************************
  // Quiet port at time zero
  initial
  begin
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_wdata_o = 8'h00;
  end
  // One byte access, held until idle or the next access
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    @(negedge sys_clk_i);
    cfg_wr_o = w;
    cfg_rd_o = ~w;
    cfg_addr_o = a;
    cfg_wdata_o = w ? d : 8'($urandom());
  endtask
  // Release; lines flip so a stale value is never mistaken for a live one
  task automatic idle();
    @(negedge sys_clk_i);
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_addr_o = ~cfg_addr_o;
    cfg_wdata_o = ~cfg_wdata_o;
  endtask
  task automatic step_up(input logic [7:0] a);
    logic [7:0] old;
    xfer(1'b0, a, 8'h00);
    idle();
    old = cfg_rdata_i;
    xfer(1'b1, a, old + 8'h01);
    idle();
  endtask
  function automatic logic [7:0] range_byte(input int msps);
    return (msps < 80) ? 8'h40 : 8'h00;
  endfunction
endmodule
`default_nettype wire

// >>> sim/atc_cfg_regs_tb.sv
// Self-checking bench for the trim and clock configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module atc_cfg_regs_tb
  import atc_pkg::*;
;
  // ****************************************
  // Stimulus and wiring
  // ****************************************
  localparam logic [63:0] MASK = 64'hffff0fffffffff0f; // Coarse 4 bits
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cal_load = 1'b0;
  logic realign = 1'b0;
  logic [63:0] cal_trim = 64'h0;
  logic [1:0] pwr_pin = PM_NAP; // Power up in nap
  logic [1:0] div_pin = 2'h0;
  logic cfg_wr, cfg_rd, port_en, div2, smp, slow;
  logic rd_d = 1'b0;
  logic [7:0] addr, wdata, rdata, c0gm, c0gf, c1oc, c1of, c1gm, c1gf;
  logic [3:0] c0gc, c1gc;
  logic [1:0] pmode;
  logic signed [6:0] p0, p1;
  logic [7:0] expq [$]; // Expected read data, oldest first
  int num_errors = 0;
  int cmp_count = 0;
  logic [7:0] exp_rd; // Oldest expected read byte
  logic [7:0] tab [6] = '{ADDR_C0_GMED, ADDR_C0_GFINE, ADDR_C1_OCOARSE,
    ADDR_C1_OFINE, ADDR_C1_GMED, ADDR_C1_GFINE};
  int slot [6] = '{1, 2, 3, 4, 6, 7};
  logic [7:0] vals [3] = '{8'h00, 8'h80, 8'hff};
  // Trim outputs gathered, byte k is calibration slot k
  wire [63:0] trims = {c1gf, c1gm, 4'h0, c1gc, c1of, c1oc, c0gf, c0gm,
    4'h0, c0gc};
  initial
  begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  atc_host_model host (.sys_clk_i(sys_clk_i), .cfg_rdata_i(rdata),
    .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_addr_o(addr),
    .cfg_wdata_o(wdata));
  atc_cfg_regs uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_addr_i(addr),
    .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cal_load_i(cal_load),
    .cal_trim_i(cal_trim), .power_mode_pin_i(pwr_pin),
    .divider_select_pin_i(div_pin), .realign_req_i(realign),
    .port_enabled_o(port_en), .power_mode_o(pmode), .divide_by2_o(div2),
    .sample_en_o(smp), .dll_slow_o(slow), .core0_gain_coarse_o(c0gc),
    .core0_gain_medium_o(c0gm), .core0_gain_fine_o(c0gf),
    .core1_offset_coarse_o(c1oc), .core1_offset_fine_o(c1of),
    .core1_gain_coarse_o(c1gc), .core1_gain_medium_o(c1gm),
    .core1_gain_fine_o(c1gf), .core0_coarse_pct_o(p0),
    .core1_coarse_pct_o(p1));
  // Read results appear one cycle after the strobe
  always @(posedge sys_clk_i)
    rd_d <= cfg_rd;
  always @(negedge sys_clk_i)
  begin
    // Pop once: the macro evaluates its expected value twice on a mismatch
    if (rd_d === 1'b1 && expq.size() > 0)
    begin
      exp_rd = expq.pop_front();
      `CHK("rdata", exp_rd, rdata)
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
    host.idle();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.xfer(1'b0, a, 8'h00);
    host.idle();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // Sampling events seen over n cycles
  task automatic cnt(input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(negedge sys_clk_i);
      k += int'(smp === 1'b1);
    end
  endtask
  // Coarse gain in tenths of a percent from the bit weights
  function automatic logic signed [6:0] pct(input logic [3:0] c);
    return 7'(28 * int'(c[3]) + 14 * int'(c[2]) - 28 * int'(c[1])
      - 14 * int'(c[0]));
  endfunction
  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int k;
    int k2;
    logic [7:0] v;
    logic [1:0] ph [2];
    void'($urandom(52));
    cal_trim = {$urandom(), $urandom()};
    cyc(2);
    rstn_i = 1'b1;
    wr(ADDR_C0_GMED, 8'h55);
    `CHK("port_en", 1'b0, port_en)
    pwr_pin = PM_NORMAL;
    k = 0;
    while (port_en !== 1'b1 && k < 20)
    begin
      cyc(1);
      k++;
    end
    if (port_en !== 1'b1)
    begin
      num_errors++;
      print_verdict();
    end
    cyc(1);
    rd(ADDR_C0_GMED, 8'h00);
    `CHK("pre cal", 64'h0, trims)
    cal_load = 1'b1;
    cyc(1);
    cal_load = 1'b0;
    `CHK("cal", cal_trim & MASK, trims)
    for (int i = 0; i < 16; i++)
    begin
      wr(ADDR_C0_GCOARSE, 8'hf0 | 8'(i));
      wr(ADDR_C1_GCOARSE, 8'(i));
      `CHK("pct0", pct(4'(i)), p0)
      `CHK("pct1", pct(4'(i)), p1)
      rd(ADDR_C0_GCOARSE, 8'(i));
    end
    foreach (tab[j])
      for (int i = 0; i < 4; i++)
      begin
        v = (i == 3) ? 8'($urandom()) : vals[i];
        wr(tab[j], v);
        `CHK("trim", v, trims[8*slot[j] +: 8])
        rd(tab[j], v);
      end
    expq.push_back(v);
    host.step_up(ADDR_C1_GFINE);
    rd(ADDR_C1_GFINE, v + 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      pwr_pin = 2'(i);
      wr(ADDR_PWR_MODE, 8'h00);
      cyc(4);
      `CHK("pin mode", 2'(i), pmode)
      wr(ADDR_PWR_MODE, 8'(((i + 1) % 3) + 1));
      cyc(2);
      `CHK("reg mode", 2'((i + 1) % 3), pmode)
    end
    for (int i = 0; i < 4; i++)
    begin
      div_pin = (i == 1 || i == 2) ? 2'h1 : 2'h0;
      wr(ADDR_CLK_DIV, (i < 2) ? 8'h00 : 8'(i - 1));
      cyc(4);
      `CHK("div2", i[0], div2)
      cnt(8, k);
      `CHK("samples", i[0] ? 4 : 8, k)
    end
    wr(ADDR_CLK_DIV, 8'h01);
    cyc(2);
    wr(ADDR_EDGE_SLIP, 8'h01);
    cnt(6, k);
    `CHK("one slip", 5, k)
    host.xfer(1'b1, ADDR_EDGE_SLIP, 8'h01);
    host.xfer(1'b1, ADDR_EDGE_SLIP, 8'h01);
    host.idle();
    // The first missing sample already stands at the release edge
    k2 = int'(smp === 1'b1);
    cnt(5, k);
    `CHK("two slips", 4, k + k2)
    wr(ADDR_EDGE_SLIP, 8'hfe);
    cnt(6, k);
    `CHK("no slip", 6, k)
    rd(ADDR_EDGE_SLIP, 8'h00);
    wr(ADDR_CLK_DIV, 8'h02);
    for (int r = 0; r < 2; r++)
    begin
      realign = 1'b1;
      cyc(10);
      ph[r][1] = smp;
      cyc(1);
      ph[r][0] = smp;
      realign = 1'b0;
      `CHK("alternate", 1'b1, ^ph[r])
      wr(ADDR_EDGE_SLIP, 8'h01);
      cyc(3);
    end
    `CHK("realign", ph[0], ph[1])
    `CHK("dll", 1'b0, slow)
    wr(ADDR_OUT_MODE_B, host.range_byte(60) | 8'hbf);
    `CHK("dll", 1'b1, slow)
    rd(ADDR_OUT_MODE_B, 8'h40);
    wr(ADDR_PWR_MODE, 8'h01);
    wr(ADDR_C0_GMED, 8'h11);
    wr(ADDR_PORT_CFG, 8'h20);
    cyc(1);
    `CHK("soft", cal_trim & MASK, trims)
    `CHK("soft dll", 1'b0, slow)
    rd(ADDR_PWR_MODE, 8'h01);
    rd(ADDR_CLK_DIV, 8'h02);
    rd(8'h50, 8'h00);
    cyc(2);
    print_verdict();
  end
endmodule
`default_nettype wire
